// ---- core/ief_pkg.sv ----
// Package of register offsets, field positions and carrier types for the interrupt and error block
package ief_pkg;

    // ****************
    // Register offsets
    // ****************
    localparam logic [7:0] IEF_ADDR_IRQ0     = 8'h06;
    localparam logic [7:0] IEF_ADDR_IRQ1     = 8'h07;
    localparam logic [7:0] IEF_ADDR_IRQ0_EN  = 8'h08;
    localparam logic [7:0] IEF_ADDR_IRQ1_EN  = 8'h09;
    localparam logic [7:0] IEF_ADDR_ERROR    = 8'h0a;
    localparam logic [7:0] IEF_ADDR_COLL_POS = 8'h0d;

    // ****************
    // Field positions
    // ****************
    localparam int IEF_BIT_SET      = 7;
    localparam int IEF_BIT_INVERT   = 7;
    localparam int IEF_BIT_PUSHPULL = 7;
    localparam int IEF_BIT_PIN_EN   = 6;
    localparam int IEF_BIT_GLOBAL   = 6;
    localparam int IEF_BIT_ERR_REQ  = 1;
    localparam int IEF_BIT_RX_DONE  = 2;
    localparam int IEF_ERR_NVM      = 7;
    localparam int IEF_ERR_WRMIS    = 6;
    localparam int IEF_ERR_OVL      = 5;
    localparam int IEF_ERR_MINFR    = 4;
    localparam int IEF_ERR_NODATA   = 3;
    localparam int IEF_ERR_COLL     = 2;
    localparam int IEF_ERR_PROT     = 1;
    localparam int IEF_ERR_INTEG    = 0;

    // ****************
    // Reset values and limits
    // ****************
    localparam logic [7:0] IEF_RST_BYTE     = 8'h00;
    localparam logic [6:0] IEF_IRQ0_MASK    = 7'h7f;
    localparam logic [6:0] IEF_IRQ1_MASK    = 7'h3f;
    localparam logic [2:0] IEF_MIN_BITS     = 3'h4;
    localparam logic [1:0] IEF_MIN_BYTES    = 2'h3;

    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ief_bus_t;

    // Events from the contactless and memory logic
    typedef struct packed {
        logic [6:0] irq0_src;
        logic [5:0] irq1_src;
        logic       nvm_fault;
        logic       fifo_wr;
        logic       fifo_full;
        logic       crc_tx_window;
        logic       rx_phase;
        logic       auth_active;
        logic       tx_due;
        logic       fifo_empty;
        logic       coll_det;
        logic       coll_in_eof;
        logic [7:0] coll_pos;
        logic       prot_err;
        logic       integ_err;
        logic       frame_end;
        logic       frame_sof;
        logic [2:0] frame_bits;
        logic [1:0] frame_bytes;
        logic       cmd_start;
        logic       rx_cmd_start;
        logic       enter_wait_data;
        logic       err_stored;
        logic       multi_frame_receive;
        logic       disturbance_suppression;
    } ief_evt_t;

endpackage

// ---- core/ief_top.sv ----
// Interrupt enable, request gathering, interrupt pin and contactless error flags
`timescale 1ns/1ps

// Notes on behaviour
// R1 - Invert bit set inverts the interrupt pin level.
// R2 - Group-0 enable bits gate their request flags into the global request.
// R3 - Five timer enables gate timer underflow requests into the global request.
// R4 - Card-detect enable gates the card detection request.
// R5 - Drive-style bit 1 drives pin both ways, 0 is open drain.
// R6 - Pin shows global request only while pin enable is set.
// R7 - Memory fault in last memory command sets memory error flag.
// R8 - FIFO write during CRC, receive phases or authentication sets misuse flag.
// R9 - Misuse flag clears at command start, or in multi-frame only after storing errors.
// R10 - Write to full FIFO sets overflow; later writes are discarded.
// R11 - Start-of-frame followed by under 4 bits sets short-frame flag.
// R12 - Short frame dropped silently; no receive-done request raised.
// R13 - With disturbance suppression, frames under 3 bytes are treated alike.
// R14 - Short-frame flag clears at receive start or entering wait-for-data.
// R15 - Transmit due with empty FIFO sets empty-transmit flag.
// R16 - Collision sets collision flag and records first collision position.
// R17 - Collision flag clears at receive start or entering wait-for-data.
// R18 - Collision inside end-of-frame symbol does not set the flag.
// R19 - Error request set when misuse, overflow, protocol, empty or integrity set.
// R20 - Request registers: bit 7 selects set or clear for written ones.
// R21 - Global request set whenever an enabled request occurs.
// R22 - Global is OR of enabled flags; pin is gated then XOR invert.
module ief_top
    import ief_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk_in,
    input  wire logic       rst_n_in,
    // Register port
    input  wire ief_bus_t   bus_in,
    output logic [7:0]      rdata_out,
    // Block events
    input  wire ief_evt_t   evt_in,
    // Effects back to the datapath
    output logic            fifo_wr_accept_out,
    output logic            rx_done_suppress_out,
    // Interrupt pin
    output logic            irq_pin_out,
    output logic            irq_pin_oe_out
);

    // ****************
    // Storage
    // ****************
    logic [7:0] irq0_en_r;
    logic [7:0] irq1_en_r;
    logic [6:0] irq0_r;
    logic [5:0] irq1_r;
    logic       global_request_r;
    logic [7:0] err_r;
    logic [7:0] coll_pos_r;
    logic [7:0] rdata_r;
    logic       fifo_acc_r;
    logic       rx_sup_r;
    logic       pin_r;
    logic       pin_oe_r;

    // Set/clear decode of a request register write
    function automatic logic [6:0] ief_setclr(input logic [6:0] cur, input logic [7:0] wd,
                                              input logic hit, input logic [6:0] msk);
        logic [6:0] sel;
        sel = hit ? (wd[6:0] & msk) : 7'h00;
        ief_setclr = wd[IEF_BIT_SET] ? (cur | sel) : (cur & ~sel);
    endfunction

    // ****************
    // Register decode
    // ****************
    wire wr_irq0 = bus_in.wr && (bus_in.addr == IEF_ADDR_IRQ0);
    wire wr_irq1 = bus_in.wr && (bus_in.addr == IEF_ADDR_IRQ1);
    wire wr_en0  = bus_in.wr && (bus_in.addr == IEF_ADDR_IRQ0_EN);
    wire wr_en1  = bus_in.wr && (bus_in.addr == IEF_ADDR_IRQ1_EN);

    // ****************
    // Frame checks
    // ****************
    wire short_bits  = evt_in.frame_end && evt_in.frame_sof && (evt_in.frame_bits < IEF_MIN_BITS); // R11
    wire short_bytes = evt_in.frame_end && evt_in.disturbance_suppression
                       && (evt_in.frame_bytes < IEF_MIN_BYTES);  // R13
    wire short_frame = short_bits || short_bytes;
    wire rx_clear    = evt_in.rx_cmd_start || evt_in.enter_wait_data;
    wire coll_hit    = evt_in.coll_det && !evt_in.coll_in_eof;  // R18
    wire misuse      = evt_in.fifo_wr && (evt_in.crc_tx_window || evt_in.rx_phase
                       || evt_in.auth_active);  // R8
    wire wr_clear    = evt_in.multi_frame_receive ? evt_in.err_stored : evt_in.cmd_start;  // R9
    wire ovl_hit     = evt_in.fifo_wr && (evt_in.fifo_full || err_r[IEF_ERR_OVL]);  // R10

    // ****************
    // Error flags, set wins over clear
    // ****************
    logic [7:0] err_nxt;
    assign err_nxt[IEF_ERR_NVM]    = evt_in.nvm_fault || (err_r[IEF_ERR_NVM] && !evt_in.cmd_start);  // R7
    assign err_nxt[IEF_ERR_WRMIS]  = misuse || (err_r[IEF_ERR_WRMIS] && !wr_clear);  // R8 R9
    assign err_nxt[IEF_ERR_OVL]    = ovl_hit || (err_r[IEF_ERR_OVL] && !evt_in.cmd_start);  // R10
    assign err_nxt[IEF_ERR_MINFR]  = short_frame || (err_r[IEF_ERR_MINFR] && !rx_clear);  // R11 R14
    assign err_nxt[IEF_ERR_NODATA] = (evt_in.tx_due && evt_in.fifo_empty)
                                     || (err_r[IEF_ERR_NODATA] && !evt_in.cmd_start);  // R15
    assign err_nxt[IEF_ERR_COLL]   = coll_hit || (err_r[IEF_ERR_COLL] && !rx_clear);  // R16 R17
    assign err_nxt[IEF_ERR_PROT]   = evt_in.prot_err || (err_r[IEF_ERR_PROT] && !rx_clear);
    assign err_nxt[IEF_ERR_INTEG]  = evt_in.integ_err || (err_r[IEF_ERR_INTEG] && !rx_clear);

    wire coll_first = coll_hit && !err_r[IEF_ERR_COLL];
    wire [7:0] coll_pos_nxt = coll_first ? evt_in.coll_pos : coll_pos_r;  // R16

    // ****************
    // Request flags
    // ****************
    wire err_any = err_nxt[IEF_ERR_WRMIS] || err_nxt[IEF_ERR_OVL] || err_nxt[IEF_ERR_PROT]
                   || err_nxt[IEF_ERR_NODATA] || err_nxt[IEF_ERR_INTEG];  // R19
    logic [6:0] irq0_src;
    always_comb
    begin
        irq0_src = evt_in.irq0_src;
        irq0_src[IEF_BIT_ERR_REQ] = err_any;  // R19
        if (short_frame)
        begin
            irq0_src[IEF_BIT_RX_DONE] = 1'b0;  // R12
        end
    end
    wire [6:0] irq0_nxt = ief_setclr(irq0_r, bus_in.wdata, wr_irq0, IEF_IRQ0_MASK) | irq0_src;  // R20
    wire [6:0] irq1_full = ief_setclr({1'b0, irq1_r}, bus_in.wdata, wr_irq1, IEF_IRQ1_MASK);  // R20
    wire [5:0] irq1_w   = irq1_full[5:0];
    wire [5:0] irq1_nxt = irq1_w | evt_in.irq1_src;

    // ****************
    // Global request and pin
    // ****************
    wire [6:0] en0_hit = irq0_nxt & irq0_en_r[6:0];  // R2
    wire [4:0] tmr_hit = irq1_nxt[4:0] & irq1_en_r[4:0];  // R3
    wire       low_power_card_detection_hit = irq1_nxt[5] & irq1_en_r[5];  // R4
    wire global_request_nxt = (|en0_hit) || (|tmr_hit) || low_power_card_detection_hit;  // R21 R22
    wire pin_req   = global_request_nxt && irq1_en_r[IEF_BIT_PIN_EN];  // R6
    wire pin_level = pin_req ^ irq0_en_r[IEF_BIT_INVERT];  // R1 R22
    wire pin_oe_nxt = irq1_en_r[IEF_BIT_PUSHPULL] ? 1'b1 : !pin_level;  // R5

    // ****************
    // Read mux
    // ****************
    logic [7:0] rd_mux;
    always_comb
    begin
        case (bus_in.addr)
            IEF_ADDR_IRQ0:     rd_mux = {1'b0, irq0_r};
            IEF_ADDR_IRQ1:     rd_mux = {1'b0, global_request_r, irq1_r};
            IEF_ADDR_IRQ0_EN:  rd_mux = irq0_en_r;
            IEF_ADDR_IRQ1_EN:  rd_mux = irq1_en_r;
            IEF_ADDR_ERROR:    rd_mux = err_r;
            IEF_ADDR_COLL_POS: rd_mux = coll_pos_r;
            default:           rd_mux = IEF_RST_BYTE;
        endcase
    end

    // ****************
    // Registers
    // ****************
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            irq0_en_r        <= IEF_RST_BYTE;
            irq1_en_r        <= IEF_RST_BYTE;
            irq0_r           <= IEF_RST_BYTE[6:0];
            irq1_r           <= IEF_RST_BYTE[5:0];
            global_request_r <= 1'b0;
            err_r            <= IEF_RST_BYTE;
            coll_pos_r       <= IEF_RST_BYTE;
            rdata_r          <= IEF_RST_BYTE;
            fifo_acc_r       <= 1'b0;
            rx_sup_r         <= 1'b0;
            pin_r            <= 1'b0;
            pin_oe_r         <= 1'b0;
        end
        else
        begin
            if (wr_en0)
            begin
                irq0_en_r <= bus_in.wdata;
            end
            if (wr_en1)
            begin
                irq1_en_r <= bus_in.wdata;
            end
            irq0_r           <= irq0_nxt;
            irq1_r           <= irq1_nxt;
            global_request_r <= global_request_nxt;
            err_r            <= err_nxt;
            coll_pos_r       <= coll_pos_nxt;
            rdata_r          <= bus_in.rd ? rd_mux : IEF_RST_BYTE;
            fifo_acc_r       <= evt_in.fifo_wr && !ovl_hit;  // R10
            rx_sup_r         <= short_frame;  // R12
            pin_r            <= pin_level;
            pin_oe_r         <= pin_oe_nxt;
        end
    end

    assign rdata_out            = rdata_r;
    assign fifo_wr_accept_out   = fifo_acc_r;
    assign rx_done_suppress_out = rx_sup_r;
    assign irq_pin_out          = pin_r;
    assign irq_pin_oe_out       = pin_oe_r;

    // ****************
    // Checks
    // ****************
    property p_pin_follow;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        1'b1 |=> irq_pin_out
                 == ((global_request_r && $past(irq1_en_r[IEF_BIT_PIN_EN])) ^ $past(irq0_en_r[IEF_BIT_INVERT]));
    endproperty
    a_pin_follow: assert property (p_pin_follow) else $error("pin level wrong"); // R1

    property p_group0;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        |(irq0_r & $past(irq0_en_r[6:0])) |-> global_request_r;
    endproperty
    a_group0: assert property (p_group0) else $error("group0 request lost"); // R2

    property p_timer;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        |(irq1_r[4:0] & $past(irq1_en_r[4:0])) |-> global_request_r;
    endproperty
    a_timer: assert property (p_timer) else $error("timer request lost"); // R3

    property p_low_power_card_detection;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (irq1_r[5] && $past(irq1_en_r[5])) |-> global_request_r;
    endproperty
    a_low_power_card_detection: assert property (p_low_power_card_detection) else $error("card detect request lost"); // R4

    property p_style;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        $past(irq1_en_r[IEF_BIT_PUSHPULL]) |-> irq_pin_oe_out;
    endproperty
    a_style: assert property (p_style) else $error("push-pull not driven"); // R5

    property p_pin_off;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (!irq1_en_r[IEF_BIT_PIN_EN] && !irq0_en_r[IEF_BIT_INVERT]) ##1 !irq1_en_r[IEF_BIT_PIN_EN] |-> !irq_pin_out;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("pin active while disabled"); // R6

    property p_ovl;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (evt_in.fifo_wr && evt_in.fifo_full) |=> err_r[IEF_ERR_OVL] && !fifo_wr_accept_out;
    endproperty
    a_ovl: assert property (p_ovl) else $error("overflow not flagged"); // R10

    property p_short;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        short_bits |=> err_r[IEF_ERR_MINFR] && rx_done_suppress_out;
    endproperty
    a_short: assert property (p_short) else $error("short frame not flagged"); // R11

    property p_eof_coll;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (evt_in.coll_in_eof && !err_r[IEF_ERR_COLL]) |=> !err_r[IEF_ERR_COLL];
    endproperty
    a_eof_coll: assert property (p_eof_coll) else $error("eof collision flagged"); // R18

    property p_nvm_set;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        evt_in.nvm_fault
        |=> err_r[IEF_ERR_NVM];
    endproperty
    a_nvm_set: assert property (p_nvm_set) else $error("memory fault not flagged"); // R7

    property p_misuse_set;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (evt_in.fifo_wr && (evt_in.crc_tx_window || evt_in.rx_phase || evt_in.auth_active))
        |=> err_r[IEF_ERR_WRMIS];
    endproperty
    a_misuse_set: assert property (p_misuse_set) else $error("fifo misuse not flagged"); // R8

    property p_misuse_clr;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (evt_in.cmd_start && !evt_in.multi_frame_receive && !evt_in.fifo_wr)
        |=> !err_r[IEF_ERR_WRMIS];
    endproperty
    a_misuse_clr: assert property (p_misuse_clr) else $error("misuse kept at command start"); // R9

    property p_misuse_stored;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (evt_in.multi_frame_receive && evt_in.err_stored && !evt_in.fifo_wr)
        |=> !err_r[IEF_ERR_WRMIS];
    endproperty
    a_misuse_stored: assert property (p_misuse_stored) else $error("misuse kept after store"); // R9

    property p_ovl_drop;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (err_r[IEF_ERR_OVL] && evt_in.fifo_wr)
        |=> !fifo_wr_accept_out;
    endproperty
    a_ovl_drop: assert property (p_ovl_drop) else $error("write taken after overflow"); // R10

    property p_short_bytes;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (evt_in.frame_end && evt_in.disturbance_suppression && (evt_in.frame_bytes < IEF_MIN_BYTES))
        |=> err_r[IEF_ERR_MINFR] && rx_done_suppress_out;
    endproperty
    a_short_bytes: assert property (p_short_bytes) else $error("short byte frame not flagged"); // R13

    property p_no_rx_done;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (short_frame && !irq0_r[IEF_BIT_RX_DONE] && !wr_irq0)
        |=> !irq0_r[IEF_BIT_RX_DONE];
    endproperty
    a_no_rx_done: assert property (p_no_rx_done) else $error("receive done on short frame"); // R12

    property p_short_clr;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        ((evt_in.rx_cmd_start || evt_in.enter_wait_data) && !evt_in.frame_end)
        |=> !err_r[IEF_ERR_MINFR];
    endproperty
    a_short_clr: assert property (p_short_clr) else $error("short frame flag not cleared"); // R14

    property p_nodata_set;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (evt_in.tx_due && evt_in.fifo_empty)
        |=> err_r[IEF_ERR_NODATA];
    endproperty
    a_nodata_set: assert property (p_nodata_set) else $error("empty transmit not flagged"); // R15

    property p_coll_set;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (evt_in.coll_det && !evt_in.coll_in_eof)
        |=> err_r[IEF_ERR_COLL];
    endproperty
    a_coll_set: assert property (p_coll_set) else $error("collision not flagged"); // R16

    property p_coll_pos;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (evt_in.coll_det && !evt_in.coll_in_eof && !err_r[IEF_ERR_COLL])
        |=> coll_pos_r == $past(evt_in.coll_pos);
    endproperty
    a_coll_pos: assert property (p_coll_pos) else $error("first collision position lost"); // R16

    property p_coll_clr;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        ((evt_in.rx_cmd_start || evt_in.enter_wait_data) && !evt_in.coll_det)
        |=> !err_r[IEF_ERR_COLL];
    endproperty
    a_coll_clr: assert property (p_coll_clr) else $error("collision flag not cleared"); // R17

    property p_err_req;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (err_r[IEF_ERR_WRMIS] || err_r[IEF_ERR_OVL] || err_r[IEF_ERR_PROT]
         || err_r[IEF_ERR_NODATA] || err_r[IEF_ERR_INTEG])
        |-> irq0_r[IEF_BIT_ERR_REQ];
    endproperty
    a_err_req: assert property (p_err_req) else $error("error request missing"); // R19

    property p_req_set;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (wr_irq0 && bus_in.wdata[IEF_BIT_SET] && bus_in.wdata[IEF_BIT_RX_DONE])
        |=> irq0_r[IEF_BIT_RX_DONE];
    endproperty
    a_req_set: assert property (p_req_set) else $error("software set lost"); // R20

    property p_global_cause;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        global_request_r
        |-> (|(irq0_r & $past(irq0_en_r[6:0]))) || (|(irq1_r & $past(irq1_en_r[5:0])));
    endproperty
    a_global_cause: assert property (p_global_cause) else $error("global request without cause"); // R21

    property p_open_drain;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        ($past(rst_n_in) && !$past(irq1_en_r[IEF_BIT_PUSHPULL]))
        |-> irq_pin_oe_out != irq_pin_out;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open drain drives high"); // R5

endmodule

// ---- test/ief_host.sv ----
// Host model that watches the interrupt wire through a pull-up
`timescale 1ns/1ps
module ief_host
(
    // Interrupt pin from the device
    input  wire logic pin_in,
    input  wire logic pin_oe_in,
    // Wire level seen by the host
    output logic      level_out
);
    // Released wire rises to the pull-up
    assign level_out = pin_oe_in ? pin_in : 1'b1;
endmodule

// ---- test/tb.sv ----
// Self-checking bench for the interrupt and error block
`timescale 1ns/1ps
module tb;
    import ief_pkg::*;
    logic        core_clk_in;
    logic        rst_n_in;
    ief_bus_t    bus;
    ief_evt_t    evt;
    ief_evt_t    e;
    logic [7:0]  rdata;
    logic [7:0]  rv;
    logic [15:0] lf;
    logic        acc;
    logic        sup;
    logic        pin;
    logic        oe;
    logic        lvl;
    logic        acc_s;
    logic        sup_s;
    logic [7:0]  al [7];
    int          fail_count;
    int          n_tests;
    int          cyc;
    int          m0;
    int          m1;
    int          n0;
    int          n1;
    int          g;
    int          lv;

    ief_top i_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .bus_in(bus), .rdata_out(rdata),
        .evt_in(evt), .fifo_wr_accept_out(acc), .rx_done_suppress_out(sup), .irq_pin_out(pin),
        .irq_pin_oe_out(oe));
    ief_host i_host (.pin_in(pin), .pin_oe_in(oe), .level_out(lvl));

    initial
    begin
        core_clk_in = 1'b0;
        forever #2 core_clk_in = ~core_clk_in;
    end

    // ****************
    // Helpers
    // ****************
    function automatic logic [15:0] nxt(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task stop_test;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge core_clk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fail_count++;
            stop_test();
        end
    end

    task chk(input string n, input logic [7:0] x, input logic [7:0] s);
        n_tests++;
        if (s !== x)
        begin
            $display("[ERR] %s expected %h seen %h", n, x, s);
            fail_count++;
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_in) bus <= '{a, d, 1'b1, 1'b0};
        @(posedge core_clk_in) bus <= '0;
    endtask

    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_in) bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge core_clk_in) bus <= '0;
        #1 d = rdata;
    endtask

    // Pulse events, then read the error flags
    task evc(input ief_evt_t x, input logic [7:0] ex);
        @(posedge core_clk_in) evt <= x;
        @(posedge core_clk_in) evt <= '0;
        #1 acc_s = acc;
        sup_s = sup;
        rd(IEF_ADDR_ERROR, rv);
        chk("error", ex, rv);
    endtask

    // Compare registers and pin with the model
    task mchk;
        g = ((m0 & n0 & 'h7f) | (m1 & n1 & 'h3f)) != 0;
        lv = (g & (n1 >> 6)) ^ (n0 >> 7);
        rd(IEF_ADDR_IRQ0, rv);
        chk("irq0", 8'(m0), rv);
        rd(IEF_ADDR_IRQ1, rv);
        chk("irq1", 8'(m1 | (g << 6)), rv);
        rd(IEF_ADDR_IRQ1_EN, rv);
        chk("en1", 8'(n1), rv);
        chk("pin", 8'(lv), {7'h00, pin});
        chk("oe", 8'((n1 >> 7) | (lv ^ 1)), {7'h00, oe});
        chk("wire", 8'(lv), {7'h00, lvl});
    endtask

    // ****************
    // Main sequence
    // ****************
    initial
    begin
        rst_n_in = 1'b0;
        bus = '0;
        evt = '0;
        cyc = 0;
        lf = 16'h7cee;
        al = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0d, 8'h20};
        repeat (20) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        #1 chk("rst oe", 8'h00, {7'h00, oe});
        chk("rst pin", 8'h00, {7'h00, pin});
        wr(8'h20, 8'hff);
        foreach (al[i])
        begin
            rd(al[i], rv);
            chk("reset", IEF_RST_BYTE, rv);
        end
        $display("test reset done");
        for (int i = 0; i < 60; i++)
        begin
            lf = nxt(lf);
            n0 = lf[7:0];
            n1 = lf[15:8];
            wr(IEF_ADDR_IRQ0_EN, lf[7:0]);
            wr(IEF_ADDR_IRQ1_EN, lf[15:8]);
            lf = nxt(lf);
            wr(IEF_ADDR_IRQ0, lf[7:0] & 8'hfd);
            m0 = lf[7] ? (m0 | (lf & 'h7d)) : (m0 & ~(lf & 'h7d));
            wr(IEF_ADDR_IRQ1, lf[15:8]);
            m1 = lf[15] ? (m1 | ((lf >> 8) & 'h3f)) : (m1 & ~((lf >> 8) & 'h3f));
            lf = nxt(lf);
            e = '0;
            e.irq0_src = lf[6:0] & 7'h7d;
            e.irq1_src = lf[13:8];
            m0 = m0 | (lf & 'h7d);
            m1 = m1 | ((lf >> 8) & 'h3f);
            evc(e, 8'h00);
            mchk();
        end
        $display("test enables done");
        wr(IEF_ADDR_IRQ0, 8'h7f);
        wr(IEF_ADDR_IRQ1, 8'h7f);
        wr(IEF_ADDR_IRQ0_EN, 8'h02);
        wr(IEF_ADDR_IRQ1_EN, 8'h40);
        e = '0;
        e.frame_end = 1'b1;
        e.frame_sof = 1'b1;
        e.frame_bits = 3'h4;
        evc(e, 8'h00);
        e.frame_bits = 3'h3;
        e.irq0_src = 7'h04;
        evc(e, 8'h10);
        chk("suppress", 8'h01, {7'h00, sup_s});
        rd(IEF_ADDR_IRQ0, rv);
        chk("irq0 short", 8'h00, rv);
        e = '0;
        e.nvm_fault = 1'b1;
        evc(e, 8'h90);
        e = '0;
        e.coll_det = 1'b1;
        e.coll_in_eof = 1'b1;
        e.coll_pos = 8'h3c;
        evc(e, 8'h90);
        e.coll_in_eof = 1'b0;
        e.coll_pos = 8'h2b;
        evc(e, 8'h94);
        e.coll_pos = 8'h11;
        evc(e, 8'h94);
        rd(IEF_ADDR_COLL_POS, rv);
        chk("coll pos", 8'h2b, rv);
        e = '0;
        e.fifo_wr = 1'b1;
        e.fifo_full = 1'b1;
        evc(e, 8'hb4);
        chk("acc full", 8'h00, {7'h00, acc_s});
        e.fifo_full = 1'b0;
        evc(e, 8'hb4);
        chk("acc after", 8'h00, {7'h00, acc_s});
        e = '0;
        e.tx_due = 1'b1;
        e.fifo_empty = 1'b1;
        evc(e, 8'hbc);
        wr(IEF_ADDR_IRQ0, 8'h02);
        rd(IEF_ADDR_IRQ0, rv);
        chk("irq0 err", 8'h02, rv);
        chk("wire err", 8'h01, {7'h00, lvl});
        e = '0;
        e.cmd_start = 1'b1;
        evc(e, 8'h14);
        e = '0;
        e.fifo_wr = 1'b1;
        e.auth_active = 1'b1;
        evc(e, 8'h54);
        e = '0;
        e.cmd_start = 1'b1;
        e.multi_frame_receive = 1'b1;
        evc(e, 8'h54);
        e.cmd_start = 1'b0;
        e.err_stored = 1'b1;
        evc(e, 8'h14);
        e = '0;
        e.fifo_wr = 1'b1;
        e.crc_tx_window = 1'b1;
        evc(e, 8'h54);
        e = '0;
        e.rx_cmd_start = 1'b1;
        evc(e, 8'h40);
        e = '0;
        e.cmd_start = 1'b1;
        evc(e, 8'h00);
        e = '0;
        e.fifo_wr = 1'b1;
        evc(e, 8'h00);
        chk("acc ok", 8'h01, {7'h00, acc_s});
        e.rx_phase = 1'b1;
        evc(e, 8'h40);
        e = '0;
        e.frame_end = 1'b1;
        e.frame_sof = 1'b1;
        e.frame_bits = 3'h7;
        e.frame_bytes = 2'h2;
        e.disturbance_suppression = 1'b1;
        evc(e, 8'h50);
        chk("suppress emd", 8'h01, {7'h00, sup_s});
        e = '0;
        e.enter_wait_data = 1'b1;
        evc(e, 8'h40);
        $display("test errors done");
        stop_test();
    end
endmodule
